// >>> hdl/headset_detect_pkg.sv
// Constants, field layouts and carriers of the headset detect controller
package headset_detect_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DET_MIN_MS = 360;
  localparam int unsigned DET_MAX_MS = 500;
  // Least duration, exact in whole cycles, so it sits inside the window
  localparam int unsigned DET_CYCLES = DET_MIN_MS * (CLK_HZ / 1000);

  // ********************************
  // Serial bus address bytes (write form, read form is plus one)
  // ********************************
  localparam logic [7:0] ADDR_WR_LOW = 8'h76;
  localparam logic [7:0] ADDR_WR_HIGH = 8'h78;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_MANUAL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ********************************
  // Field positions
  // ********************************
  localparam int CTRL_AUTO_DIS = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_PULL = 3;
  localparam int CTRL_TRIG = 4;
  localparam int ST_PRESENT = 0;
  localparam int ST_POL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_PIN = 3;
  localparam int IRQ_DONE = 0;

  // ********************************
  // Reset values
  // ********************************
  localparam logic AUTO_DIS_RST = 1'b0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic PULL_RST = 1'b0;
  localparam logic [2:0] PRESET_RST = 3'h0;
  localparam logic [3:0] MANUAL_RST = 4'h0;
  localparam logic MASK_RST = 1'b0;

  // ********************************
  // Modes and preset codes
  // ********************************
  localparam logic [1:0] IND_PRESENCE = 2'h0;
  localparam logic [1:0] IND_IRQ = 2'h1;
  localparam logic [1:0] IND_OFF = 2'h2;
  localparam logic [2:0] PRE_ISOLATE = 3'h0;
  localparam logic [2:0] PRE_MIC_RING2 = 3'h2;
  localparam logic [2:0] PRE_MIC_SLEEVE = 3'h3;
  localparam logic [2:0] PRE_GND_BOTH = 3'h4;
  localparam logic [2:0] PRE_RING2_ONLY = 3'h5;
  localparam logic [2:0] PRE_SLEEVE_ONLY = 3'h6;
  localparam logic [2:0] PRE_MANUAL = 3'h7;

  // ********************************
  // Carriers
  // ********************************
  typedef struct packed {
    logic mic_ring2;
    logic mic_sleeve;
    logic gnd_ring2;
    logic gnd_sleeve;
  } switch_t;

  typedef struct packed {
    logic present;
    logic mic_sleeve;
  } det_t;

endpackage : headset_detect_pkg

// >>> hdl/headset_mic_detect_control.sv
// Detection sequencer, switch routing, indicator and registers
//
// Contract
// [R1] Each detection finds whether a microphone is present and on which contact.
// [R2] With auto routing on, a found microphone is routed to its contact.
// [R3] The microphone ground is routed to the other contact at the same time.
// [R4] A detection starts from the bus trigger command or the start input.
// [R5] Only a low-to-high edge of the start input starts a detection.
// [R6] Software can disable auto routing so results leave the switches alone; the code instead sets the isolation preset after each detection.
// [R7] Software can open or close every switch on its own.
// [R8] Address bytes 76/77 answer with select low and 78/79 with select high.
// [R9] In presence mode the indicator is low from a found microphone until the next result.
// [R10] In interrupt mode the indicator signals that new results are ready.
// [R11] A detection finishes 360 to 500 ms after it starts.
// [R12] The indicator mode is presence, interrupt or disabled.
// [R13] With auto routing off the preset returns to isolation after a detection.
// [R14] The start input is synchronised and starts during a detection are ignored.
`timescale 1ns/100ps
module headset_mic_detect_control #(
  parameter int unsigned DET_CYCLES = headset_detect_pkg::DET_CYCLES
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial address byte from the bus front end
  input wire logic [7:0] i_addr_byte,
  input wire logic i_addr_stb,
  output logic o_addr_ack,
  output logic o_addr_rd,
  // Pins
  input wire logic i_detect_start_input,
  input wire logic i_addr_sel,
  input wire logic i_sense_ring2,
  input wire logic i_sense_sleeve,
  // Open-drain active-low indicator
  input wire logic i_mic_present_n,
  output logic o_mic_present_n,
  output logic o_mic_present_n_oe,
  // Switches and interrupt
  output headset_detect_pkg::switch_t o_sw,
  output logic o_irq
);

  localparam int CNT_W = $clog2(DET_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  // ********************************
  // Functions
  // ********************************
  function automatic headset_detect_pkg::switch_t sw_of_preset(
    input logic [2:0] code,
    input headset_detect_pkg::switch_t manual
  );
    headset_detect_pkg::switch_t s;
    s = '0;
    unique case (code)
      headset_detect_pkg::PRE_MIC_RING2: begin
        s.mic_ring2 = 1'b1;
        s.gnd_sleeve = 1'b1;
      end
      headset_detect_pkg::PRE_MIC_SLEEVE: begin
        s.mic_sleeve = 1'b1;
        s.gnd_ring2 = 1'b1;
      end
      headset_detect_pkg::PRE_GND_BOTH: begin
        s.gnd_ring2 = 1'b1;
        s.gnd_sleeve = 1'b1;
      end
      headset_detect_pkg::PRE_RING2_ONLY: s.mic_ring2 = 1'b1;
      headset_detect_pkg::PRE_SLEEVE_ONLY: s.mic_sleeve = 1'b1;
      headset_detect_pkg::PRE_MANUAL: s = manual; // see [R7]
      default: s = '0;
    endcase
    return s;
  endfunction : sw_of_preset

  function automatic logic addr_hit(
    input logic [7:0] byte_in,
    input logic sel
  );
    logic [7:0] base;
    base = sel ? headset_detect_pkg::ADDR_WR_HIGH
               : headset_detect_pkg::ADDR_WR_LOW;
    return byte_in[7:1] == base[7:1];
  endfunction : addr_hit

  // ********************************
  // Pin synchronisers
  // ********************************
  // Order: start, addr_sel, ring2 sense, sleeve sense, indicator pin
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic start_prev;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      start_prev <= 1'b0;
    end else begin
      sync_a <= {i_mic_present_n, i_sense_sleeve, i_sense_ring2,
                 i_addr_sel, i_detect_start_input}; // see [R14]
      sync_b <= sync_a;
      start_prev <= sync_b[0];
    end
  end

  logic pin_start;
  assign pin_start = sync_b[0] && !start_prev; // see [R5]

  // ********************************
  // APB decode
  // ********************************
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite && mapped;
  assign rd = access && !i_pwrite && mapped;

  always_comb begin
    unique case (i_paddr)
      headset_detect_pkg::OFS_CTRL,
      headset_detect_pkg::OFS_PRESET,
      headset_detect_pkg::OFS_MANUAL,
      headset_detect_pkg::OFS_STATUS,
      headset_detect_pkg::OFS_IRQ_STAT,
      headset_detect_pkg::OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states; an unmapped address is answered with an error
  assign o_pready = access;
  assign o_pslverr = access && !mapped;

  // ********************************
  // Control registers
  // ********************************
  logic auto_dis;
  logic [1:0] ind_mode;
  logic pull_man;
  headset_detect_pkg::switch_t manual;
  logic irq_mask;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      auto_dis <= headset_detect_pkg::AUTO_DIS_RST;
      ind_mode <= headset_detect_pkg::MODE_RST;
      pull_man <= headset_detect_pkg::PULL_RST;
    end else if (wr && i_paddr == headset_detect_pkg::OFS_CTRL) begin
      auto_dis <= i_pwdata[headset_detect_pkg::CTRL_AUTO_DIS]; // see [R6]
      ind_mode <= i_pwdata[headset_detect_pkg::CTRL_MODE_LSB +: 2];
      pull_man <= i_pwdata[headset_detect_pkg::CTRL_PULL];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      manual <= headset_detect_pkg::MANUAL_RST;
    end else if (wr && i_paddr == headset_detect_pkg::OFS_MANUAL) begin
      manual <= i_pwdata[3:0]; // see [R7]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_mask <= headset_detect_pkg::MASK_RST;
    end else if (wr && i_paddr == headset_detect_pkg::OFS_IRQ_MASK) begin
      irq_mask <= i_pwdata[headset_detect_pkg::IRQ_DONE];
    end
  end

  logic bus_trig;
  assign bus_trig = wr && i_paddr == headset_detect_pkg::OFS_CTRL &&
                    i_pwdata[headset_detect_pkg::CTRL_TRIG];

  // ********************************
  // Detection sequencer
  // ********************************
  state_t state;
  logic [CNT_W-1:0] det_cnt;
  headset_detect_pkg::det_t result;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      det_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Requests while running are dropped, not queued
          if (bus_trig || pin_start) begin // see [R4] see [R14]
            state <= ST_RUN;
            det_cnt <= '0;
          end
        end
        ST_RUN: begin
          if (det_cnt == CNT_W'(DET_CYCLES - 1)) begin // see [R11]
            state <= ST_DONE;
          end else begin
            det_cnt <= det_cnt + 1'b1;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sense levels are taken at the end so the jack has settled
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result <= '0;
    end else if (state == ST_DONE) begin
      result.present <= sync_b[2] || sync_b[3]; // see [R1]
      result.mic_sleeve <= sync_b[3] && !sync_b[2]; // see [R1]
    end
  end

  // ********************************
  // Switch preset
  // ********************************
  logic [2:0] preset;
  logic [2:0] next_preset;

  always_comb begin
    next_preset = preset;
    if (state == ST_DONE) begin
      if (auto_dis) begin
        next_preset = headset_detect_pkg::PRE_ISOLATE; // see [R13]
      end else if (!(sync_b[2] || sync_b[3])) begin
        // Three-pole plug: both contacts to ground
        next_preset = headset_detect_pkg::PRE_GND_BOTH;
      end else if (sync_b[3] && !sync_b[2]) begin
        next_preset = headset_detect_pkg::PRE_MIC_SLEEVE; // see [R2] see [R3]
      end else begin
        next_preset = headset_detect_pkg::PRE_MIC_RING2; // see [R2] see [R3]
      end
    end else if (wr && i_paddr == headset_detect_pkg::OFS_PRESET) begin
      next_preset = i_pwdata[2:0]; // see [R7]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      preset <= headset_detect_pkg::PRESET_RST;
    end else begin
      preset <= next_preset;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sw <= '0;
    end else begin
      o_sw <= sw_of_preset(preset, manual);
    end
  end

  // ********************************
  // Interrupt status
  // ********************************
  logic irq_done;
  logic clr_irq;

  assign clr_irq = rd && i_paddr == headset_detect_pkg::OFS_IRQ_STAT;

  // A result in the clearing cycle stays set
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_done <= 1'b0;
    end else if (state == ST_DONE) begin
      irq_done <= 1'b1;
    end else if (clr_irq) begin
      irq_done <= 1'b0;
    end
  end

  assign o_irq = irq_done && irq_mask;

  // ********************************
  // Indicator pin
  // ********************************
  logic ind_pull;

  always_comb begin
    unique case (ind_mode)
      headset_detect_pkg::IND_PRESENCE: ind_pull = result.present; // see [R9]
      headset_detect_pkg::IND_IRQ: ind_pull = o_irq; // see [R10]
      default: ind_pull = 1'b0; // see [R12]
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mic_present_n_oe <= 1'b0;
    end else begin
      o_mic_present_n_oe <= ind_pull || pull_man; // see [R12]
    end
  end

  assign o_mic_present_n = 1'b0;

  // ********************************
  // Serial address match
  // ********************************
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_addr_ack <= 1'b0;
      o_addr_rd <= 1'b0;
    end else begin
      o_addr_ack <= i_addr_stb && addr_hit(i_addr_byte, sync_b[1]); // see [R8]
      if (i_addr_stb) begin
        o_addr_rd <= i_addr_byte[0];
      end
    end
  end

  // ********************************
  // Read data
  // ********************************
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (i_paddr)
      headset_detect_pkg::OFS_CTRL: begin
        rdata[headset_detect_pkg::CTRL_AUTO_DIS] = auto_dis;
        rdata[headset_detect_pkg::CTRL_MODE_LSB +: 2] = ind_mode;
        rdata[headset_detect_pkg::CTRL_PULL] = pull_man;
      end
      headset_detect_pkg::OFS_PRESET: rdata[2:0] = preset;
      headset_detect_pkg::OFS_MANUAL: rdata[3:0] = manual;
      headset_detect_pkg::OFS_STATUS: begin
        rdata[headset_detect_pkg::ST_PRESENT] = result.present;
        rdata[headset_detect_pkg::ST_POL] = result.mic_sleeve;
        rdata[headset_detect_pkg::ST_BUSY] = state != ST_IDLE;
        rdata[headset_detect_pkg::ST_PIN] = sync_b[4];
      end
      headset_detect_pkg::OFS_IRQ_STAT:
        rdata[headset_detect_pkg::IRQ_DONE] = irq_done;
      headset_detect_pkg::OFS_IRQ_MASK:
        rdata[headset_detect_pkg::IRQ_DONE] = irq_mask;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle, so it is stable through the access
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_prdata <= rdata;
    end
  end

endmodule : headset_mic_detect_control

// >>> tb/addr_front_model.sv
// Serial bus front end model that strobes address bytes
`timescale 1ns/100ps
module addr_front_model (
  // Clock
  input wire logic i_sys_clk,
  // Request from the bench
  input wire logic i_go,
  input wire logic [7:0] i_byte,
  // To the controller
  output logic [7:0] o_addr_byte,
  output logic o_addr_stb
);
  initial begin
    o_addr_byte = 8'h00;
    o_addr_stb = 1'b0;
  end
  // Byte is only valid with the strobe; it toggles otherwise
  always @(posedge i_sys_clk) begin
    o_addr_stb <= i_go;
    o_addr_byte <= i_go ? i_byte : ~o_addr_byte;
  end
endmodule : addr_front_model

// >>> tb/headset_mic_detect_control_sva.sv
// Port assertions of the headset detect controller
`timescale 1ns/100ps
module headset_mic_detect_control_sva (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Address match and pins
  input wire logic [7:0] i_addr_byte,
  input wire logic i_addr_stb,
  input wire logic o_addr_ack,
  input wire logic o_addr_rd,
  input wire logic i_addr_sel,
  input wire logic o_mic_present_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Select is synchronised, so only judge a match once it has settled
  logic [3:0] sel_hist;
  logic steady;
  logic [6:0] own;
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_hist <= 4'h0;
    end else begin
      sel_hist <= {sel_hist[2:0], i_addr_sel};
    end
  end
  assign steady = (sel_hist == {4{i_addr_sel}});
  assign own = i_addr_sel ? headset_detect_pkg::ADDR_WR_HIGH[7:1] :
    headset_detect_pkg::ADDR_WR_LOW[7:1];

  pready_acc_a:
  assert property (o_pready == (i_psel && i_penable))
    else $error("pready outside access cycle");
  err_access_a:
  assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slverr outside access cycle");
  err_data_a:
  assert property (o_pslverr |-> o_prdata == 32'h0)
    else $error("refused read returned data");
  addr_match_a:
  assert property (i_addr_stb && steady && i_addr_byte[7:1] == own
    |=> o_addr_ack) else $error("own address not acknowledged");
  addr_refuse_a:
  assert property (i_addr_stb && steady && i_addr_byte[7:1] != own
    |=> !o_addr_ack) else $error("foreign address acknowledged");
  ack_cause_a:
  assert property (o_addr_ack |-> $past(i_addr_stb))
    else $error("ack without strobe");
  rd_bit_a:
  assert property (i_addr_stb |=> o_addr_rd == $past(i_addr_byte[0]))
    else $error("direction bit not kept");
  od_zero_a:
  assert property (o_mic_present_n == 1'b0)
    else $error("indicator drives high");
endmodule : headset_mic_detect_control_sva

bind headset_mic_detect_control headset_mic_detect_control_sva u_sva (
  .i_sys_clk, .i_rst_b, .i_psel, .i_penable, .o_prdata, .o_pready,
  .o_pslverr, .i_addr_byte, .i_addr_stb, .o_addr_ack, .o_addr_rd,
  .i_addr_sel, .o_mic_present_n
);

// >>> tb/headset_mic_detect_control_test.sv
// Self-checking bench of the headset detect controller
`timescale 1ns/100ps
module headset_mic_detect_control_test;
  localparam int DET = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] abyte;
  logic [7:0] gbyte = 8'h00;
  logic astb, ack, ard, oe, od, irq, pin, exp_ack;
  logic go = 1'b0;
  logic start = 1'b0;
  logic sel = 1'b0;
  logic s_r2 = 1'b0;
  logic s_sl = 1'b0;
  headset_detect_pkg::switch_t sw;
  logic [31:0] rdat;
  logic perr;
  int fail_count = 0;
  int num_checks = 0;
  typedef struct packed {
    logic [2:0] pre;
    logic [3:0] sw;
  } row_t;
  // Preset code beside the switches it closes; 7 follows MANUAL = A
  row_t rows [8] = '{'{3'h0, 4'h0}, '{3'h1, 4'h0}, '{3'h2, 4'h9},
    '{3'h3, 4'h6}, '{3'h4, 4'h3}, '{3'h5, 4'h8}, '{3'h6, 4'h4},
    '{3'h7, 4'hA}};

  always #10 clk = ~clk;
  // Open-drain indicator with pull-up
  assign pin = oe ? od : 1'b1;

  addr_front_model u_addr_front_model (.i_sys_clk(clk), .i_go(go),
    .i_byte(gbyte), .o_addr_byte(abyte), .o_addr_stb(astb));
  headset_mic_detect_control #(.DET_CYCLES(DET)) u_headset_mic_detect_control (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_addr_byte(abyte), .i_addr_stb(astb), .o_addr_ack(ack),
    .o_addr_rd(ard), .i_detect_start_input(start), .i_addr_sel(sel),
    .i_sense_ring2(s_r2), .i_sense_sleeve(s_sl), .i_mic_present_n(pin),
    .o_mic_present_n(od), .o_mic_present_n_oe(oe), .o_sw(sw), .o_irq(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // A repeat start while busy must not stretch the run
  task automatic detect(input logic by_pin, input logic [31:0] ctrl,
                        input logic [3:0] old);
    if (by_pin) begin
      start <= 1'b1;
      @(posedge clk);
    end else begin
      apb(1'b1, headset_detect_pkg::OFS_CTRL, ctrl | 32'h10);
    end
    repeat (4) @(posedge clk);
    apb(1'b1, headset_detect_pkg::OFS_CTRL, ctrl | 32'h10);
    repeat (DET - 12) @(posedge clk);
    check(sw, old);
    repeat (by_pin ? 11 : 8) @(posedge clk);
  endtask : detect

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("MISMATCH %0t: timeout", $time);
    report_and_stop;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, headset_detect_pkg::OFS_CTRL, 32'h0);
    check(rdat, 32'h0);
    check(sw, 4'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({perr, rdat[30:0]}, 32'h80000000);
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      for (int b = 0; b < 4; b++) begin
        repeat (4) @(posedge clk);
        go <= 1'b1;
        gbyte <= 8'h76 + b[7:0];
        exp_ack = ((8'h76 + b[7:0]) >> 1) == (s[0] ?
          headset_detect_pkg::ADDR_WR_HIGH >> 1 :
          headset_detect_pkg::ADDR_WR_LOW >> 1);
        @(posedge clk);
        go <= 1'b0;
        // Ack stands for one cycle; look at it away from the launching edge
        @(posedge clk);
        @(negedge clk);
        check({ard, ack}, {b[0], exp_ack});
        @(posedge clk);
      end
    end
    apb(1'b1, headset_detect_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, headset_detect_pkg::OFS_MANUAL, 32'hA);
    foreach (rows[i]) begin
      apb(1'b1, headset_detect_pkg::OFS_PRESET, {29'h0, rows[i].pre});
      repeat (2) @(posedge clk);
      check(sw, rows[i].sw);
    end
    apb(1'b1, headset_detect_pkg::OFS_CTRL, 32'h0);
    s_r2 <= 1'b1;
    detect(1'b0, 32'h0, 4'hA);
    check(sw, 4'h9);
    check(oe, 1'b1);
    apb(1'b0, headset_detect_pkg::OFS_STATUS, 32'h0);
    check(rdat, 32'h1);
    s_r2 <= 1'b0;
    s_sl <= 1'b1;
    detect(1'b1, 32'h0, 4'h9);
    check(sw, 4'h6);
    apb(1'b0, headset_detect_pkg::OFS_STATUS, 32'h0);
    check(rdat, 32'h3);
    // Pin stays high: a level alone must not start another run
    s_sl <= 1'b0;
    repeat (DET + 10) @(posedge clk);
    check(sw, 4'h6);
    start <= 1'b0;
    detect(1'b0, 32'h0, 4'h6);
    check(sw, 4'h3);
    check(oe, 1'b0);
    apb(1'b1, headset_detect_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, headset_detect_pkg::OFS_PRESET, 32'h2);
    s_r2 <= 1'b1;
    detect(1'b0, 32'h1, 4'h9);
    check(sw, 4'h0);
    apb(1'b0, headset_detect_pkg::OFS_PRESET, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, headset_detect_pkg::OFS_IRQ_STAT, 32'h0);
    apb(1'b1, headset_detect_pkg::OFS_CTRL, 32'h2);
    detect(1'b0, 32'h2, 4'h0);
    check(irq, 1'b0);
    apb(1'b1, headset_detect_pkg::OFS_IRQ_MASK, 32'h1);
    @(posedge clk);
    check({irq, oe}, 2'h3);
    apb(1'b0, headset_detect_pkg::OFS_IRQ_STAT, 32'h0);
    check(rdat, 32'h1);
    @(posedge clk);
    check({irq, oe}, 2'h0);
    apb(1'b1, headset_detect_pkg::OFS_CTRL, 32'h4);
    s_r2 <= 1'b0;
    s_sl <= 1'b1;
    detect(1'b0, 32'h4, 4'h9);
    check(sw, 4'h6);
    check(oe, 1'b0);
    report_and_stop;
  end
endmodule : headset_mic_detect_control_test
